// >>> design/fci_pkg.sv
// constants for the frame command interpreter
`default_nettype none
package fci_pkg;
  // frame layout, byte indices counted from zero
  localparam logic [3:0] IDX_CMD_LO = 4'h1;
  localparam logic [3:0] IDX_PAR_LO = 4'h9;
  localparam logic [3:0] IDX_RSV = 4'ha;
  localparam logic [3:0] IDX_LAST = 4'hb;
  localparam logic [7:0] RSV_BYTE = 8'h00;
  // general commands and their answer codes
  localparam logic [15:0] CMD_PING = 16'hfe01;
  localparam logic [15:0] ANS_PING = 16'hff01;
  localparam logic [15:0] CMD_IDENT = 16'hfe02;
  localparam logic [15:0] ANS_IDENT = 16'hff02;
  localparam logic [15:0] CMD_HWVER = 16'hfe06;
  localparam logic [15:0] ANS_HWVER = 16'hff06;
  localparam logic [15:0] CMD_FWVER = 16'hfe07;
  localparam logic [15:0] ANS_FWVER = 16'hff07;
  localparam logic [15:0] CMD_SERIAL = 16'hfe08;
  localparam logic [15:0] ANS_SERIAL = 16'hff08;
  localparam logic [15:0] CMD_NAME = 16'hfe09;
  localparam logic [15:0] ANS_NAME = 16'hff09;
  // input select and controller dump commands
  localparam logic [15:0] CMD_INPUT_SEL = 16'h0030;
  localparam logic [15:0] ANS_INPUT_SEL = 16'h0130;
  localparam logic [15:0] CMD_CTRL_DUMP = 16'h0031;
  localparam logic [15:0] ANS_CTRL_DUMP = 16'h0131;
  // error replies
  localparam logic [15:0] CHECKSUM_FAIL_REPLY = 16'hff10;
  localparam logic [15:0] RESEND_REPLY = 16'hff11;
  localparam logic [15:0] BAD_PARAMETER_REPLY = 16'hff12;
  localparam logic [15:0] UNKNOWN_COMMAND_REPLY = 16'hff13;
  // identity and version, values arbitrary
  localparam logic [63:0] DEVICE_ID = 64'h0000_0000_0000_00a5;
  localparam logic [23:0] HW_VERSION = 24'h01_00_00;
  localparam logic [23:0] FW_VERSION = 24'h01_00_00;
  // serial number and name text, eight characters each, arbitrary
  localparam logic [63:0] SERIAL_TEXT = 64'h3030_3030_3030_3031;
  localparam logic [63:0] NAME_TEXT = 64'h5445_4320_4354_524c;
  localparam logic [63:0] TEXT_LEN = 64'h0000_0000_0000_0008;
  // sensor input codes
  localparam logic [7:0] IN_THERM1 = 8'h00;
  localparam logic [7:0] IN_THERM2 = 8'h01;
  localparam logic [7:0] IN_RES1 = 8'h03;
  localparam logic [7:0] IN_RES2 = 8'h04;
  // input select status values, dump tab character and dump field count
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_OK_FAULT = 8'h0a;
  localparam logic [7:0] TAB_CHAR = 8'h09;
  localparam logic [2:0] DUMP_FIELDS = 3'h6;
  // inter-byte timeout and answer fifo depth
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_US = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TX_FIFO_DEPTH = 4;
  // interpreter state
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_EXEC = 3'b010,
    ST_TX = 3'b100
  } fci_state_t;
endpackage
`default_nettype wire

// >>> design/fci_top.sv
// frame command interpreter with its answer fifo
//
// Overview of operation
// - twelve consecutive bytes, else timeout discards frame
// - command then parameter, most significant first
// - reserved byte eleven is always zero
// - byte twelve is xor of first eleven
// - every good frame gets a twelve-byte answer
// - bad parameter answers bad_parameter_reply
// - unknown command answers unknown_command_reply
// - checksum failure answers checksum_fail_reply
// - resend request makes sender repeat last frame
// - presence check answers zero, changes nothing
// - identify returns device identifier
// - hw_version_query returns three version bytes
// - fw_version_query returns three version bytes
// - serial_number_query: zero gives length, else character
// - name_string_query: zero gives length, else character
// - fault turns output off, status adds ten
// - fault cleared by toggling enable before rearm
// - input select applies only while enable low
// - controller dump returns six controller values
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module fci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [DEPTH-1:0] vld_q;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] shv;
  logic pop;
  logic push;

  // shift fifo: head always sits in entry zero
  assign pop = vld_q[0] & out_ready_i;
  assign in_ready_o = ~vld_q[DEPTH-1];
  assign push = in_valid_i & in_ready_o;
  assign out_valid_o = vld_q[0];
  assign out_data_o = mem_q[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic nxt_v;
    logic [WIDTH-1:0] nxt_d;
    logic tgt;
    if (i == DEPTH - 1) begin : g_last
      assign nxt_v = 1'b0;
      assign nxt_d = mem_q[i];
    end else begin : g_mid
      assign nxt_v = vld_q[i+1];
      assign nxt_d = mem_q[i+1];
    end
    assign shv[i] = pop ? nxt_v : vld_q[i];
    if (i == 0) begin : g_first
      assign tgt = ~shv[0];
    end else begin : g_rest
      assign tgt = ~shv[i] & shv[i-1];
    end
    // each entry shifts down on pop and takes new data when targeted
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        vld_q[i] <= 1'b0;
        mem_q[i] <= '0;
      end else if (push && tgt) begin
        vld_q[i] <= 1'b1;
        mem_q[i] <= in_data_i;
      end else begin
        vld_q[i] <= shv[i];
        if (pop) begin
          mem_q[i] <= nxt_d;
        end
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module fci_top import fci_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  input wire logic enable_i,
  input wire logic single_mode_i,
  input wire logic fault_i,
  input wire logic [95:0] ctl_ch0_i,
  input wire logic [95:0] ctl_ch1_i,
  output logic pulse_on_o,
  output logic fault_latched_o,
  output logic [7:0] input_sel0_o,
  output logic [7:0] input_sel1_o,
  output logic frame_timeout_o
);
  fci_state_t st_q;
  logic [3:0] idx_q;
  logic [31:0] to_cnt_q;
  logic [15:0] cmd_q;
  logic [63:0] par_q;
  logic [7:0] rsv_q;
  logic [7:0] acc_q;
  logic cks_ok_q;
  logic [15:0] ans_cmd_q;
  logic [63:0] ans_par_q;
  logic [15:0] ans_cmd_d;
  logic [63:0] ans_par_d;
  logic [3:0] tx_idx_q;
  logic [7:0] tx_acc_q;
  logic [7:0] tx_byte_c;
  logic fifo_rdy;
  logic rx_fire;
  logic push;
  logic en_s1_q, en_s2_q, en_q;
  logic sm_s1_q, sm_s2_q;
  logic fault_q;
  logic pulse_q;
  logic tmo_q;
  logic [7:0] pend0_q, pend1_q, sel0_q, sel1_q;
  logic do_sel;
  logic sel_ch;
  logic [7:0] sel_val;

  // a character of eight-character text, position one first
  function automatic logic [63:0] text_char(input logic [63:0] s,
                                            input logic [63:0] k);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (k == 64'(i + 1)) begin
        r[7:0] = s[8*(7-i) +: 8];
      end
    end
    return r;
  endfunction

  assign rx_fire = rx_valid_i & st_q[0];
  assign rx_ready_o = st_q[0];
  assign push = st_q[2] & fifo_rdy;
  assign pulse_on_o = pulse_q;
  assign fault_latched_o = fault_q;
  assign input_sel0_o = sel0_q;
  assign input_sel1_o = sel1_q;
  assign frame_timeout_o = tmo_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_q <= 1'b0;
      sm_s1_q <= 1'b0;
      sm_s2_q <= 1'b0;
    end else begin
      en_s1_q <= enable_i;
      en_s2_q <= en_s1_q;
      en_q <= en_s2_q;
      sm_s1_q <= single_mode_i;
      sm_s2_q <= sm_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interpreter state machine
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_RX;
    end else begin
      case (st_q)
        ST_RX: if (rx_fire && idx_q == IDX_LAST) st_q <= ST_EXEC;
        ST_EXEC: st_q <= ST_TX;
        ST_TX: if (push && tx_idx_q == IDX_LAST) st_q <= ST_RX;
        default: st_q <= ST_RX;
      endcase
    end
  end

  // byte assembly, checksum accumulation and inter-byte timeout
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idx_q <= '0;
      to_cnt_q <= '0;
      cmd_q <= '0;
      par_q <= '0;
      rsv_q <= '0;
      acc_q <= '0;
      cks_ok_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      tmo_q <= 1'b0;
      if (rx_fire) begin
        to_cnt_q <= '0;
        acc_q <= acc_q ^ rx_byte_i;
        if (idx_q <= IDX_CMD_LO) begin
          cmd_q <= {cmd_q[7:0], rx_byte_i};
        end else if (idx_q <= IDX_PAR_LO) begin
          par_q <= {par_q[55:0], rx_byte_i};
        end else if (idx_q == IDX_RSV) begin
          rsv_q <= rx_byte_i;
        end
        if (idx_q == IDX_LAST) begin
          cks_ok_q <= (acc_q == rx_byte_i);
          idx_q <= '0;
          acc_q <= '0;
        end else begin
          idx_q <= idx_q + 4'h1;
        end
      end else if (st_q == ST_RX && idx_q != 4'h0) begin
        if (to_cnt_q == 32'(TIMEOUT_CYCLES - 1)) begin
          idx_q <= '0;
          acc_q <= '0;
          to_cnt_q <= '0;
          tmo_q <= 1'b1;
        end else begin
          to_cnt_q <= to_cnt_q + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of a received frame into answer and side effect
  always_comb begin
    logic [7:0] ch;
    logic [63:0] ctl;
    ch = sm_s2_q ? 8'h00 : par_q[15:8];
    ctl = '0;
    ans_cmd_d = UNKNOWN_COMMAND_REPLY;
    ans_par_d = '0;
    do_sel = 1'b0;
    sel_ch = ch[0];
    sel_val = par_q[7:0];
    if (!cks_ok_q) begin
      ans_cmd_d = CHECKSUM_FAIL_REPLY;
    end else if (rsv_q != RSV_BYTE) begin
      ans_cmd_d = RESEND_REPLY;
    end else begin
      case (cmd_q)
        CMD_PING: ans_cmd_d = ANS_PING;
        CMD_IDENT: begin
          ans_cmd_d = ANS_IDENT;
          ans_par_d = DEVICE_ID;
        end
        CMD_HWVER: begin
          ans_cmd_d = ANS_HWVER;
          ans_par_d = {40'h0, HW_VERSION};
        end
        CMD_FWVER: begin
          ans_cmd_d = ANS_FWVER;
          ans_par_d = {40'h0, FW_VERSION};
        end
        CMD_SERIAL: begin
          ans_cmd_d = ANS_SERIAL;
          ans_par_d = (par_q == 64'h0) ? TEXT_LEN
                      : text_char(SERIAL_TEXT, par_q);
        end
        CMD_NAME: begin
          ans_cmd_d = ANS_NAME;
          ans_par_d = (par_q == 64'h0) ? TEXT_LEN
                      : text_char(NAME_TEXT, par_q);
        end
        CMD_INPUT_SEL: begin
          ans_cmd_d = ANS_INPUT_SEL;
          ans_par_d[7:0] = fault_q ? STAT_OK_FAULT : STAT_OK;
          do_sel = (ch <= 8'h01) && (par_q[63:16] == 48'h0)
                   && (sm_s2_q ? par_q[15:8] == 8'h00 : 1'b1)
                   && (sel_val == IN_THERM1 || sel_val == IN_THERM2
                   || sel_val == IN_RES1 || sel_val == IN_RES2);
          if (!do_sel) ans_cmd_d = BAD_PARAMETER_REPLY;
        end
        CMD_CTRL_DUMP: begin
          ans_cmd_d = ANS_CTRL_DUMP;
          ctl = ch[0] ? {32'h0, ctl_ch1_i[95:64]} : {32'h0, ctl_ch0_i[95:64]};
          for (int f = 0; f < 6; f++) begin
            if (par_q[2:0] == 3'(f)) begin
              ans_par_d[15:0] = ch[0] ? ctl_ch1_i[16*(5-f) +: 16]
                                      : ctl_ch0_i[16*(5-f) +: 16];
            end
          end
          if (par_q[2:0] < DUMP_FIELDS - 3'h1) begin
            ans_par_d[23:16] = TAB_CHAR;
          end
          // single mode leaves no room for a channel byte
          if (ch > 8'h01 || par_q[2:0] >= DUMP_FIELDS
              || (sm_s2_q && par_q[15:8] != 8'h00)
              || par_q[63:16] != 48'h0 || ctl[63]) begin
            ans_cmd_d = BAD_PARAMETER_REPLY;
          end
        end
        default: ans_cmd_d = UNKNOWN_COMMAND_REPLY;
      endcase
      if ((cmd_q[15:8] == 8'hfe) && (cmd_q != CMD_SERIAL)
          && (cmd_q != CMD_NAME) && (par_q != 64'h0)
          && (ans_cmd_d != UNKNOWN_COMMAND_REPLY)) begin
        ans_cmd_d = BAD_PARAMETER_REPLY;
      end
      if ((cmd_q == CMD_SERIAL || cmd_q == CMD_NAME)
          && par_q > TEXT_LEN) begin
        ans_cmd_d = BAD_PARAMETER_REPLY;
      end
      if (ans_cmd_d == BAD_PARAMETER_REPLY) begin
        ans_par_d = '0;
      end
    end
  end

  // answer capture
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ans_cmd_q <= '0;
      ans_par_q <= '0;
    end else if (st_q == ST_EXEC) begin
      ans_cmd_q <= ans_cmd_d;
      ans_par_q <= ans_par_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending and active input selection per channel
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend0_q <= IN_THERM1;
      pend1_q <= IN_THERM1;
      sel0_q <= IN_THERM1;
      sel1_q <= IN_THERM1;
    end else begin
      if (st_q == ST_EXEC && do_sel && cks_ok_q) begin
        if (sel_ch) pend1_q <= sel_val;
        else pend0_q <= sel_val;
      end
      if (!en_q) begin
        sel0_q <= pend0_q;
        sel1_q <= pend1_q;
      end
    end
  end

  // fault latch: set wins, a falling enable acknowledges it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      if (fault_i) fault_q <= 1'b1;
      else if (!en_s2_q && en_q) fault_q <= 1'b0;
      pulse_q <= en_q & ~fault_q & ~fault_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer serialiser into the fifo
  always_comb begin
    tx_byte_c = ans_par_q[7:0];
    case (tx_idx_q)
      4'h0: tx_byte_c = ans_cmd_q[15:8];
      4'h1: tx_byte_c = ans_cmd_q[7:0];
      IDX_RSV: tx_byte_c = RSV_BYTE;
      IDX_LAST: tx_byte_c = tx_acc_q;
      default: tx_byte_c = ans_par_q[8*(9-tx_idx_q) +: 8];
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_idx_q <= '0;
      tx_acc_q <= '0;
    end else if (push) begin
      tx_acc_q <= (tx_idx_q == IDX_LAST) ? 8'h00 : tx_acc_q ^ tx_byte_c;
      tx_idx_q <= (tx_idx_q == IDX_LAST) ? 4'h0 : tx_idx_q + 4'h1;
    end
  end

  fci_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(st_q[2]),
    .in_data_i(tx_byte_c),
    .in_ready_o(fifo_rdy),
    .out_valid_o(tx_valid_o),
    .out_data_o(tx_byte_o),
    .out_ready_i(tx_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_TIMEOUT_DROP: assert property (
    (st_q == ST_RX && idx_q != 4'h0 && !rx_fire
     && to_cnt_q == 32'(TIMEOUT_CYCLES - 1)) |=> idx_q == 4'h0 && tmo_q)
    else $error("partial frame not dropped on timeout");
  AST_ANSWER_STARTS: assert property (
    st_q == ST_EXEC |=> st_q == ST_TX && tx_idx_q == 4'h0)
    else $error("answer frame not started");
  AST_TX_RSV_ZERO: assert property (
    push && tx_idx_q == IDX_RSV |-> tx_byte_c == 8'h00)
    else $error("reserved answer byte not zero");
  AST_TX_CKSUM: assert property (
    push && tx_idx_q == IDX_LAST |-> tx_byte_c == tx_acc_q)
    else $error("answer checksum wrong");
  AST_CKSUM_FAIL: assert property (
    st_q == ST_EXEC && !cks_ok_q |=> ans_cmd_q == CHECKSUM_FAIL_REPLY)
    else $error("checksum failure not answered");
  AST_UNKNOWN: assert property (
    st_q == ST_EXEC && cks_ok_q && rsv_q == 8'h00 && cmd_q == 16'h1234
    |=> ans_cmd_q == UNKNOWN_COMMAND_REPLY)
    else $error("unknown command not answered");
  AST_PING_BADPAR: assert property (
    st_q == ST_EXEC && cks_ok_q && rsv_q == 8'h00 && cmd_q == CMD_PING
    && par_q != 64'h0 |=> ans_cmd_q == BAD_PARAMETER_REPLY)
    else $error("bad ping parameter not answered");
  AST_PING: assert property (
    st_q == ST_EXEC && cks_ok_q && rsv_q == 8'h00 && cmd_q == CMD_PING
    && par_q == 64'h0 |=> ans_cmd_q == ANS_PING && ans_par_q == 64'h0)
    else $error("ping answer wrong");
  AST_FAULT_OFF: assert property (
    fault_q |=> !pulse_on_o)
    else $error("output on while fault latched");
  AST_SEL_HOLD: assert property (
    en_q |=> $stable(input_sel0_o) && $stable(input_sel1_o))
    else $error("input selection changed while enabled");
  AST_NO_SIDE: assert property (
    st_q == ST_EXEC && !cks_ok_q |=> $stable(pend0_q) && $stable(pend1_q))
    else $error("bad frame changed state");
endmodule
`default_nettype wire

// >>> verif/fci_host_model.sv
// host controller model that sends command frames and collects answers
`default_nettype none
module fci_host_model import fci_pkg::*; (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] frame_q [12];

  ////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'ha5;
    tx_ready_o = 1'b0;
  end

  // push the stored frame back to back, stopping after n bytes
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      rx_valid_o <= 1'b1;
      rx_byte_o <= frame_q[i];
      do @(posedge clk_i); while (!rx_ready_i);
    end
    rx_valid_o <= 1'b0;
    // released data line must not keep showing the last byte
    rx_byte_o <= ~frame_q[n-1];
  endtask

  // build a frame; rsv and flip let a test spoil it on purpose
  task automatic send(input logic [15:0] cmd, input logic [63:0] par,
                      input logic [7:0] rsv, input logic [7:0] flip,
                      input int n);
    logic [7:0] sum;
    {frame_q[0], frame_q[1]} = cmd;
    for (int i = 0; i < 8; i++) frame_q[2+i] = par[63-8*i -: 8];
    frame_q[10] = rsv;
    sum = 8'h00;
    for (int i = 0; i < 11; i++) sum ^= frame_q[i];
    frame_q[11] = sum ^ flip;
    push(n);
  endtask

  // collect one answer; stall keeps ready low two cycles in three
  task automatic recv(input logic stall, output logic [15:0] cmd,
                      output logic [63:0] par, output logic [7:0] rsv,
                      output logic [7:0] sum);
    logic [7:0] b [12];
    int k;
    int t;
    k = 0;
    t = 0;
    sum = 8'h00;
    tx_ready_o <= 1'b1;
    while (k < 12 && t < 600) begin
      @(posedge clk_i);
      t++;
      if (tx_valid_i && tx_ready_o) begin
        b[k] = tx_byte_i;
        sum ^= tx_byte_i;
        k++;
      end
      tx_ready_o <= (k < 12) && (!stall || (t % 3 == 0));
    end
    cmd = {b[0], b[1]};
    for (int i = 0; i < 8; i++) par[63-8*i -: 8] = b[2+i];
    rsv = b[10];
    if (k < 12) sum = 8'hxx;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the frame command interpreter
`default_nettype none
module tb_top import fci_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 20;
  localparam int LIMIT = 20000;
  logic core_clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready;
  logic enable, single_mode, fault, pulse_on, fault_latched, frame_timeout;
  logic [7:0] rx_byte, tx_byte, input_sel0, input_sel1;
  logic [95:0] ctl_ch0, ctl_ch1;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////////
  // design and host model
  fci_top #(.TIMEOUT_CYCLES(TMO)) fci_top_inst (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .rx_valid_i(rx_valid),
    .rx_byte_i(rx_byte), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
    .tx_byte_o(tx_byte), .tx_ready_i(tx_ready), .enable_i(enable),
    .single_mode_i(single_mode), .fault_i(fault), .ctl_ch0_i(ctl_ch0),
    .ctl_ch1_i(ctl_ch1), .pulse_on_o(pulse_on),
    .fault_latched_o(fault_latched), .input_sel0_o(input_sel0),
    .input_sel1_o(input_sel1), .frame_timeout_o(frame_timeout)
  );
  fci_host_model fci_host_model_inst (
    .clk_i(core_clk), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
    .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
    .tx_ready_o(tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one request and its answer; m: 1 reserved set, 2 bad sum, 4 stall,
  // 8 repeat the last frame unchanged
  task automatic xact(input logic [15:0] c, input logic [63:0] p,
                      input logic [15:0] ec, input logic [63:0] ep,
                      input logic [3:0] m);
    logic [15:0] ac;
    logic [63:0] ap;
    logic [7:0] rs;
    logic [7:0] xs;
    if (m[3]) begin
      fci_host_model_inst.push(12);
    end else begin
      fci_host_model_inst.send(c, p, {7'h0, m[0]}, {7'h0, m[1]}, 12);
    end
    fci_host_model_inst.recv(m[2], ac, ap, rs, xs);
    chk(ac, ec);
    chk(ap, ep);
    chk(rs, 8'h00);
    chk(xs, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_general();
    xact(CMD_PING, 64'h0, ANS_PING, 64'h0, 4'h0);
    xact(CMD_IDENT, 64'h0, ANS_IDENT, DEVICE_ID, 4'h0);
    xact(CMD_HWVER, 64'h0, ANS_HWVER, {40'h0, HW_VERSION}, 4'h0);
    xact(CMD_FWVER, 64'h0, ANS_FWVER, {40'h0, FW_VERSION}, 4'h4);
    xact(CMD_SERIAL, 64'h0, ANS_SERIAL, TEXT_LEN, 4'h0);
    xact(CMD_SERIAL, 64'h1, ANS_SERIAL, {56'h0, SERIAL_TEXT[63:56]}, 0);
    xact(CMD_NAME, 64'h0, ANS_NAME, TEXT_LEN, 4'h0);
    xact(CMD_NAME, 64'h8, ANS_NAME, {56'h0, NAME_TEXT[7:0]}, 4'h0);
    xact(CMD_NAME, 64'h9, BAD_PARAMETER_REPLY, 64'h0, 4'h0);
    xact(CMD_IDENT, 64'h1, BAD_PARAMETER_REPLY, 64'h0, 4'h0);
    $display("test general done");
  endtask

  task automatic t_errors();
    xact(16'h1234, 64'h0, UNKNOWN_COMMAND_REPLY, 64'h0, 4'h0);
    xact(CMD_PING, 64'h0, CHECKSUM_FAIL_REPLY, 64'h0, 4'h2);
    xact(CMD_PING, 64'h0, RESEND_REPLY, 64'h0, 4'h1);
    xact(CMD_PING, 64'h0, RESEND_REPLY, 64'h0, 4'h8);
    $display("test errors done");
  endtask

  task automatic t_timeout();
    int seen;
    seen = 0;
    fci_host_model_inst.send(CMD_PING, 64'h0, 8'h00, 8'h00, 5);
    repeat (TMO + 6) begin
      @(posedge core_clk);
      if (frame_timeout === 1'b1) seen++;
    end
    chk(seen, 1);
    xact(CMD_IDENT, 64'h0, ANS_IDENT, DEVICE_ID, 4'h0);
    $display("test timeout done");
  endtask

  task automatic t_select();
    xact(CMD_INPUT_SEL, 64'h103, ANS_INPUT_SEL, 64'h0, 4'h0);
    tick(4);
    chk(input_sel1, IN_RES1);
    xact(CMD_INPUT_SEL, 64'h2, BAD_PARAMETER_REPLY, 64'h0, 4'h0);
    xact(CMD_INPUT_SEL, 64'h4, CHECKSUM_FAIL_REPLY, 64'h0, 4'h2);
    tick(4);
    chk(input_sel0, IN_THERM1);
    enable <= 1'b1;
    tick(5);
    xact(CMD_INPUT_SEL, 64'h4, ANS_INPUT_SEL, 64'h0, 4'h0);
    tick(4);
    chk(input_sel0, IN_THERM1);
    enable <= 1'b0;
    tick(5);
    chk(input_sel0, IN_RES2);
    chk(input_sel1, IN_RES1);
    $display("test select done");
  endtask

  task automatic t_fault();
    enable <= 1'b1;
    tick(5);
    chk(pulse_on, 1'b1);
    fault <= 1'b1;
    tick(1);
    fault <= 1'b0;
    tick(2);
    chk(fault_latched, 1'b1);
    chk(pulse_on, 1'b0);
    xact(CMD_INPUT_SEL, 64'h103, ANS_INPUT_SEL,
         {56'h0, STAT_OK_FAULT}, 4'h0);
    chk(pulse_on, 1'b0);
    enable <= 1'b0;
    tick(5);
    enable <= 1'b1;
    tick(5);
    chk(fault_latched, 1'b0);
    chk(pulse_on, 1'b1);
    xact(CMD_INPUT_SEL, 64'h103, ANS_INPUT_SEL,
         {56'h0, STAT_OK}, 4'h0);
    enable <= 1'b0;
    tick(5);
    $display("test fault done");
  endtask

  task automatic t_dump();
    logic [63:0] e;
    for (int f = 0; f < 6; f++) begin
      e = {40'h0, ((f < 5) ? TAB_CHAR : 8'h00), ctl_ch1[95-16*f -: 16]};
      xact(CMD_CTRL_DUMP, 64'h100 | 64'(f), ANS_CTRL_DUMP, e, 4'h4);
    end
    xact(CMD_CTRL_DUMP, 64'h6, BAD_PARAMETER_REPLY, 64'h0, 4'h0);
    single_mode <= 1'b1;
    tick(4);
    xact(CMD_CTRL_DUMP, 64'h101, BAD_PARAMETER_REPLY, 64'h0, 4'h0);
    e = {40'h0, TAB_CHAR, ctl_ch0[79:64]};
    xact(CMD_CTRL_DUMP, 64'h1, ANS_CTRL_DUMP, e, 4'h0);
    single_mode <= 1'b0;
    tick(4);
    $display("test dump done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    enable = 1'b0;
    single_mode = 1'b0;
    fault = 1'b0;
    ctl_ch0 = 96'h1111_2222_3333_4444_5555_6666;
    ctl_ch1 = 96'ha1a2_b3b4_c5c6_d7d8_e9ea_0f0e;
    tick(11);
    chk(rx_ready, 1'b1);
    chk(tx_valid, 1'b0);
    chk(input_sel0, 8'h00);
    tick(1);
    rst_n <= 1'b1;
    tick(2);
    t_general();
    t_errors();
    t_timeout();
    t_select();
    t_fault();
    t_dump();
    conclude();
  end
endmodule
`default_nettype wire
